// *** core/dscp_map_pkg.sv ***
// shared constants, layouts and state types of the dscp priority map slice
package dscp_map_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam int REG_IDX_W = 8;
   localparam logic [7:0] IDX_MAP_2C_2F = 8'h6B;
   localparam logic [7:0] IDX_MAP_30_33 = 8'h6C;
   localparam logic [7:0] IDX_MAP_34_37 = 8'h6D;
   localparam logic [7:0] IDX_STATUS = 8'h70;
   localparam logic [7:0] IDX_HIT_COUNT = 8'h71;
   localparam logic [21:0] ADDR_UPPER_ZERO = 22'h000000;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] MAP_RESET = 8'h00;
   localparam logic [15:0] HIT_COUNT_RESET = 16'h0000;
   localparam logic [1:0] PRIO_LOWEST = 2'h0;

   // ----------------------------------------------------------------
   // codepoint extraction and field layout
   // ----------------------------------------------------------------
   localparam int DSCP_MSB = 7;
   localparam int DSCP_LSB = 2;
   localparam int FIELD_W = 2;
   localparam logic [5:0] CP_SLICE_FIRST = 6'h2C;
   localparam logic [5:0] CP_SLICE_LAST = 6'h37;
   localparam logic [5:0] CP_2C = 6'h2C;
   localparam logic [5:0] CP_2D = 6'h2D;
   localparam logic [5:0] CP_2E = 6'h2E;
   localparam logic [5:0] CP_2F = 6'h2F;
   localparam int FLD_LO = 0;
   localparam int FLD_1 = 2;
   localparam int FLD_2 = 4;
   localparam int FLD_HI = 6;

   // status register layout
   localparam int STAT_CP_LSB = 0;
   localparam int STAT_PRIO_LSB = 6;
   localparam int STAT_HIT_BIT = 8;

   // ----------------------------------------------------------------
   // ahb-lite encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [7:0] tos;
   } class_req_t;

   typedef struct packed {
      logic valid;
      logic hit;
      logic [5:0] codepoint;
      logic [1:0] prio;
   } class_rsp_t;

   typedef struct packed {
      logic en;
      logic [7:0] idx;
      logic [31:0] data;
   } reg_wr_t;

   // ----------------------------------------------------------------
   // module state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [31:0] rdata;
      logic ready;
      logic resp;
   } port_state_t;

   typedef struct packed {
      logic [7:0] map_2c_2f;
      logic [7:0] map_30_33;
      logic [7:0] map_34_37;
      logic [5:0] last_cp;
      logic [1:0] last_prio;
      logic last_hit;
      logic [15:0] hit_cnt;
      class_rsp_t rsp;
   } slice_state_t;

endpackage

// *** core/dscp_ahb_port.sv ***
// ahb-lite slave front end for the dscp map slice registers
module dscp_ahb_port (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output dscp_map_pkg::reg_wr_t reg_wr,
   output logic [7:0] rd_idx,
   output logic rd_mapped,
   input wire logic [31:0] rd_data
);

   dscp_map_pkg::port_state_t s_q;
   dscp_map_pkg::port_state_t s_d;
   logic take;
   logic mapped;

   // ----------------------------------------------------------------
   // address phase
   // ----------------------------------------------------------------
   // only whole-word singles are expected; hsize is not checked
   assign take = hsel & hready & htrans[1];
   assign mapped = (haddr[31:10] == dscp_map_pkg::ADDR_UPPER_ZERO);
   assign rd_idx = haddr[9:2];
   assign rd_mapped = mapped;

   // write lands at the end of its data phase, read data is captured
   // at the end of the address phase so hrdata comes from a flop
   assign reg_wr = '{en: s_q.wr_pend, idx: s_q.wr_idx, data: hwdata};

   always_comb begin
      s_d = s_q;
      s_d.wr_pend = 1'b0;
      s_d.ready = 1'b1;
      s_d.resp = dscp_map_pkg::HRESP_OKAY;
      if (take) begin
         s_d.wr_pend = hwrite & mapped;
         s_d.wr_idx = haddr[9:2];
         if (!hwrite) begin
            s_d.rdata = mapped ? rd_data : 32'h00000000;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '{wr_pend: 1'b0, wr_idx: 8'h00, rdata: 32'h00000000, ready: 1'b1, resp: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign hrdata = s_q.rdata;
   assign hreadyout = s_q.ready;
   assign hresp = s_q.resp;

   wire unused_hsize = ^hsize;

endmodule // dscp_ahb_port

// *** core/dscp_priority_map_slice.sv ***
// dscp to priority map slice: codepoints 0x2c..0x37, three map registers
//
// Overview of operation
// - codepoint is tos byte bits seven to two
// - codepoint 0x2f uses bits 7-6 below 0x6c
// - codepoint 0x2e uses bits 5-4 there
// - codepoint 0x2d uses bits 3-2 there
// - codepoint 0x2c uses bits 1-0 there
// - register 0x6c maps 0x30..0x33, low pair first
// - register 0x6d maps 0x34..0x37, low pair first
// - map fields read/write, reset to 00
module dscp_priority_map_slice (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire dscp_map_pkg::class_req_t class_req,
   output dscp_map_pkg::class_rsp_t class_rsp
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // codepoint of a tos or traffic class byte
   function automatic logic [5:0] codepoint_of(input logic [7:0] tos);
      codepoint_of = tos[dscp_map_pkg::DSCP_MSB:dscp_map_pkg::DSCP_LSB];
   endfunction

   // codepoint falls inside this slice
   function automatic logic in_slice(input logic [5:0] cp);
      in_slice = (cp >= dscp_map_pkg::CP_SLICE_FIRST) && (cp <= dscp_map_pkg::CP_SLICE_LAST);
   endfunction

   // pick one 2-bit field out of a map byte, low pair first
   function automatic logic [1:0] field_of(input logic [7:0] map, input logic [1:0] sel);
      logic [1:0] f;
      f = dscp_map_pkg::PRIO_LOWEST;
      case (sel)
         2'h0: f = map[dscp_map_pkg::FLD_LO +: dscp_map_pkg::FIELD_W];
         2'h1: f = map[dscp_map_pkg::FLD_1 +: dscp_map_pkg::FIELD_W];
         2'h2: f = map[dscp_map_pkg::FLD_2 +: dscp_map_pkg::FIELD_W];
         2'h3: f = map[dscp_map_pkg::FLD_HI +: dscp_map_pkg::FIELD_W];
         default: f = dscp_map_pkg::PRIO_LOWEST;
      endcase
      field_of = f;
   endfunction

   // priority for a codepoint of the lowest map register
   function automatic logic [1:0] prio_low_reg(input logic [7:0] map, input logic [5:0] cp);
      logic [1:0] p;
      p = dscp_map_pkg::PRIO_LOWEST;
      case (cp)
         dscp_map_pkg::CP_2F: p = map[dscp_map_pkg::FLD_HI +: dscp_map_pkg::FIELD_W];
         dscp_map_pkg::CP_2E: p = map[dscp_map_pkg::FLD_2 +: dscp_map_pkg::FIELD_W];
         dscp_map_pkg::CP_2D: p = map[dscp_map_pkg::FLD_1 +: dscp_map_pkg::FIELD_W];
         dscp_map_pkg::CP_2C: p = map[dscp_map_pkg::FLD_LO +: dscp_map_pkg::FIELD_W];
         default: p = dscp_map_pkg::PRIO_LOWEST;
      endcase
      prio_low_reg = p;
   endfunction

   // full slice lookup; codepoints outside the slice give the lowest priority
   function automatic logic [1:0] lookup(input dscp_map_pkg::slice_state_t st, input logic [5:0] cp);
      logic [5:0] off;
      logic [1:0] p;
      off = cp - dscp_map_pkg::CP_SLICE_FIRST;
      p = dscp_map_pkg::PRIO_LOWEST;
      if (in_slice(cp)) begin
         case (off[3:2])
            2'h0: p = prio_low_reg(st.map_2c_2f, cp);
            2'h1: p = field_of(st.map_30_33, off[1:0]);
            2'h2: p = field_of(st.map_34_37, off[1:0]);
            default: p = dscp_map_pkg::PRIO_LOWEST;
         endcase
      end
      lookup = p;
   endfunction

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   dscp_map_pkg::reg_wr_t reg_wr;
   logic [7:0] rd_idx;
   logic rd_mapped;
   logic [31:0] rd_data;

   dscp_ahb_port u_port (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hwdata(hwdata),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .reg_wr(reg_wr),
      .rd_idx(rd_idx),
      .rd_mapped(rd_mapped),
      .rd_data(rd_data)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   dscp_map_pkg::slice_state_t s_q;
   dscp_map_pkg::slice_state_t s_d;
   logic [5:0] req_cp;
   logic req_hit;
   logic [1:0] req_prio;
   logic cnt_clear;

   assign req_cp = codepoint_of(class_req.tos);
   assign req_hit = in_slice(req_cp);
   // lookup uses the maps as they stand before this edge's write, so a
   // write only steers frames offered after it has landed
   assign req_prio = lookup(s_q, req_cp);
   assign cnt_clear = reg_wr.en && (reg_wr.idx == dscp_map_pkg::IDX_HIT_COUNT);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;

      // software writes to the map fields, low byte only
      if (reg_wr.en) begin
         case (reg_wr.idx)
            dscp_map_pkg::IDX_MAP_2C_2F: s_d.map_2c_2f = reg_wr.data[7:0];
            dscp_map_pkg::IDX_MAP_30_33: s_d.map_30_33 = reg_wr.data[7:0];
            dscp_map_pkg::IDX_MAP_34_37: s_d.map_34_37 = reg_wr.data[7:0];
            default: s_d.map_2c_2f = s_q.map_2c_2f;
         endcase
      end

      // classification answer, one cycle after the request
      s_d.rsp.valid = class_req.valid;
      if (class_req.valid) begin
         s_d.rsp.hit = req_hit;
         s_d.rsp.codepoint = req_cp;
         s_d.rsp.prio = req_prio;
         s_d.last_cp = req_cp;
         s_d.last_prio = req_prio;
         s_d.last_hit = req_hit;
      end

      // hit counter: a hit in the clearing cycle still counts
      if (cnt_clear) begin
         s_d.hit_cnt = dscp_map_pkg::HIT_COUNT_RESET;
      end
      if (class_req.valid && req_hit) begin
         s_d.hit_cnt = (cnt_clear ? dscp_map_pkg::HIT_COUNT_RESET : s_q.hit_cnt) + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   // reads look at next-state maps so a write in the same edge is seen
   always_comb begin
      rd_data = 32'h00000000;
      if (rd_mapped) begin
         case (rd_idx)
            dscp_map_pkg::IDX_MAP_2C_2F: rd_data[7:0] = s_d.map_2c_2f;
            dscp_map_pkg::IDX_MAP_30_33: rd_data[7:0] = s_d.map_30_33;
            dscp_map_pkg::IDX_MAP_34_37: rd_data[7:0] = s_d.map_34_37;
            dscp_map_pkg::IDX_STATUS: begin
               rd_data[dscp_map_pkg::STAT_CP_LSB +: 6] = s_q.last_cp;
               rd_data[dscp_map_pkg::STAT_PRIO_LSB +: 2] = s_q.last_prio;
               rd_data[dscp_map_pkg::STAT_HIT_BIT] = s_q.last_hit;
            end
            dscp_map_pkg::IDX_HIT_COUNT: rd_data[15:0] = s_q.hit_cnt;
            default: rd_data = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q.map_2c_2f <= dscp_map_pkg::MAP_RESET;
         s_q.map_30_33 <= dscp_map_pkg::MAP_RESET;
         s_q.map_34_37 <= dscp_map_pkg::MAP_RESET;
         s_q.last_cp <= 6'h00;
         s_q.last_prio <= dscp_map_pkg::PRIO_LOWEST;
         s_q.last_hit <= 1'b0;
         s_q.hit_cnt <= dscp_map_pkg::HIT_COUNT_RESET;
         s_q.rsp <= '{valid: 1'b0, hit: 1'b0, codepoint: 6'h00, prio: 2'h0};
      end else begin
         s_q <= s_d;
      end
   end

   assign class_rsp = s_q.rsp;

endmodule // dscp_priority_map_slice

// *** verif/dscp_map_slice_assertions.sv ***
// concurrent checks on the ports of the dscp priority map slice
module dscp_map_slice_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire dscp_map_pkg::class_req_t class_req,
   input wire dscp_map_pkg::class_rsp_t class_rsp
);
   default clocking dcb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_rsp_follows_req: assert property (class_req.valid |=> class_rsp.valid)
      else $error("no answer one cycle after a request");
   chk_rsp_one_pulse: assert property (!class_req.valid |=> !class_rsp.valid)
      else $error("answer without a request");
   chk_cp_from_tos: assert property (class_req.valid |=> class_rsp.codepoint == $past(class_req.tos[7:2]))
      else $error("codepoint not taken from tos bits 7 to 2");
   chk_hit_window: assert property (class_req.valid |=> class_rsp.hit ==
      ($past(class_req.tos[7:2]) >= 6'h2C && $past(class_req.tos[7:2]) <= 6'h37))
      else $error("hit flag wrong for codepoint");
   chk_miss_lowest: assert property (class_rsp.valid && !class_rsp.hit |-> class_rsp.prio == 2'h0)
      else $error("miss gives nonzero priority");
   chk_fields_hold: assert property (!class_req.valid |=> $stable(class_rsp.codepoint) && $stable(class_rsp.prio))
      else $error("answer fields moved without a request");
   chk_bus_okay: assert property (hreadyout && hresp == dscp_map_pkg::HRESP_OKAY)
      else $error("bus not ready or not okay");
   chk_map_upper_zero: assert property (hsel && hready && htrans[1] && !hwrite && haddr[31:10] == 22'h0 &&
      haddr[9:2] >= 8'h6B && haddr[9:2] <= 8'h6D |=> hrdata[31:8] == 24'h0)
      else $error("map read shows upper bits");
   chk_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite && haddr[31:10] != 22'h0
      |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule // dscp_map_slice_chk

bind dscp_priority_map_slice dscp_map_slice_chk dscp_map_slice_chk_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .class_req(class_req), .class_rsp(class_rsp)
);

// *** verif/dscp_priority_map_slice_tb.sv ***
// self-checking bench for the dscp priority map slice
module dscp_priority_map_slice_tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [7:0] tos;
      logic hit;
      logic [1:0] prio;
   } row_t;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   dscp_map_pkg::class_req_t class_req = '0;
   dscp_map_pkg::class_rsp_t class_rsp;
   logic [31:0] rd;
   int failures = 0;
   int total_checks = 0;
   logic [31:0] maps [3] = '{32'h000001AC, 32'h000001B0, 32'h000001B4};
   logic [31:0] vals [3] = '{32'hFFFFFFE4, 32'hFFFFFF1B, 32'hFFFFFF9C};
   // low tos bits set on purpose: they must not reach the codepoint
   row_t rows [14] = '{'{8'hB0, 1'b1, 2'h0}, '{8'hB5, 1'b1, 2'h1}, '{8'hBA, 1'b1, 2'h2},
      '{8'hBF, 1'b1, 2'h3}, '{8'hC0, 1'b1, 2'h3}, '{8'hC5, 1'b1, 2'h2}, '{8'hCA, 1'b1, 2'h1},
      '{8'hCF, 1'b1, 2'h0}, '{8'hD0, 1'b1, 2'h0}, '{8'hD6, 1'b1, 2'h3}, '{8'hD9, 1'b1, 2'h1},
      '{8'hDF, 1'b1, 2'h2}, '{8'hAF, 1'b0, 2'h0}, '{8'hE0, 1'b0, 2'h0}};

   dscp_priority_map_slice dscp_priority_map_slice_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .class_req(class_req), .class_rsp(class_rsp)
   );

   always #12.5 hclk = ~hclk;

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wait_rdy();
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   // one single ahb transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
      hsel <= 1'b1;
      haddr <= addr;
      hwrite <= wr;
      htrans <= dscp_map_pkg::HTRANS_NONSEQ;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wdata;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic cls(input row_t r);
      class_req <= '{valid: 1'b1, tos: r.tos};
      @(posedge hclk);
      class_req <= '0;
      @(negedge hclk);
      chk("class_rsp", 32'(class_rsp), 32'({1'b1, r.hit, r.tos[7:2], r.prio}));
      @(posedge hclk);
   endtask

   task automatic maps_zero();
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, maps[i], 32'h0);
         chk("map after reset", rd, 32'h0);
      end
   endtask

   task automatic close_out();
      if (failures == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      maps_zero();
      cls('{8'hBF, 1'b1, 2'h0});
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, maps[i], vals[i]);
         bus(1'b0, maps[i], 32'h0);
         chk("map readback", rd, {24'h0, vals[i][7:0]});
      end
      foreach (rows[i]) cls(rows[i]);
      // alias of the first map above the decoded window must be ignored
      bus(1'b1, 32'h000005AC, 32'h000000FF);
      bus(1'b0, 32'h000005AC, 32'h0);
      chk("unmapped read", rd, 32'h0);
      bus(1'b0, maps[0], 32'h0);
      chk("map untouched", rd, 32'h000000E4);
      bus(1'b1, maps[0], 32'h0000001B);
      // a write to the hit count register at 0x1c4 clears the hit counter
      bus(1'b1, 32'h000001C4, 32'h0);
      cls('{8'hBC, 1'b1, 2'h0});
      cls('{8'hB3, 1'b1, 2'h3});
      bus(1'b0, 32'h000001C4, 32'h0);
      chk("hit count", rd, 32'h00000002);
      bus(1'b0, 32'h000001C0, 32'h0);
      chk("status", rd, 32'h000001EC);
      // a frame taken at the edge the write lands still sees the old map
      fork
         bus(1'b1, maps[2], 32'h0);
         begin
            @(posedge hclk);
            cls('{8'hD6, 1'b1, 2'h3});
         end
      join
      cls('{8'hD6, 1'b1, 2'h0});
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      maps_zero();
      cls('{8'hDC, 1'b1, 2'h0});
      close_out();
   end

   // a hang ends the run with a failure
   initial begin
      #(25 * 4000);
      failures++;
      close_out();
   end
endmodule // dscp_priority_map_slice_tb
